// ---- lsc_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the conversion control block.
`ifndef LSC_CFG_SVH
`define LSC_CFG_SVH

// ****************************************************************
// Register layout
// ****************************************************************
`define LSC_CFG_OFFSET 8'h01
`define LSC_RANGE_MSB 15
`define LSC_RANGE_LSB 12
`define LSC_CTIME_BIT 11
`define LSC_MODE_MSB 10
`define LSC_MODE_LSB 9
`define LSC_OVF_BIT 8
`define LSC_RESET_WORD 16'hC810
`define LSC_RANGE_RESET 4'hC
`define LSC_CTIME_RESET 1'h1
`define LSC_LOWCTL_RESET 5'h10
`define LSC_AUTO_CODE 4'hC
`define LSC_RANGE_MAX 4'hB
`define LSC_RANGE_LOSSY 4'h5

// ****************************************************************
// Timing
// ****************************************************************
`define LSC_CLK_MHZ 200
`define LSC_T_SHORT_MS 100
`define LSC_T_LONG_MS 800
`define LSC_SHORT_CYCLES (`LSC_T_SHORT_MS * 1000 * `LSC_CLK_MHZ)
`define LSC_LONG_CYCLES (`LSC_T_LONG_MS * 1000 * `LSC_CLK_MHZ)

`endif

// ---- lsc_pkg.sv ----
// Types shared by the conversion control block.
package lsc_pkg;
   // Controller states, Gray coded along idle, convert, finish.
   typedef enum logic [1:0] {
      LSC_IDLE = 2'h0,
      LSC_CONV = 2'h1,
      LSC_FINISH = 2'h3
   } lsc_state_t;
   // Operating modes of the mode field.
   typedef enum logic [1:0] {
      LSC_SHUTDOWN = 2'h0,
      LSC_SINGLE = 2'h1,
      LSC_CONT_A = 2'h2,
      LSC_CONT_B = 2'h3
   } lsc_mode_t;
   typedef logic [3:0] lsc_range_t;
endpackage : lsc_pkg

// ---- lsc_conv_if.sv ----
// Interface between the controller and its conversion timer.
`timescale 1ns/10ps
`default_nettype none
interface lsc_conv_if;
   logic start;    // High one cycle per launch, back to back while auto range steps up: begin a conversion, restarting any running one.
   logic abort;    // One-cycle pulse: stop the running conversion.
   logic longTime; // Level: long conversion time selected.
   logic done;     // One-cycle pulse: the conversion time has elapsed.
   modport ctrl (output start, output abort, output longTime, input done);
   modport timer (input start, input abort, input longTime, output done);
endinterface : lsc_conv_if
`default_nettype wire

// ---- lsc_conv_timer.sv ----
// Conversion timer: counts out the short or the long conversion time.
`timescale 1ns/10ps
`default_nettype none
`include "lsc_cfg.svh"
module lsc_conv_timer
   import lsc_pkg::*;
#(
   parameter int unsigned SHORT_CYCLES = `LSC_SHORT_CYCLES,
   parameter int unsigned LONG_CYCLES = `LSC_LONG_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Controller side
   lsc_conv_if.timer conv
);
   logic [31:0] count;   // Cycles spent in the running conversion.
   logic running;        // A conversion is being timed.
   wire [31:0] target;   // Length of the running conversion in cycles.
   wire atEnd;           // Last cycle of the running conversion.

   assign target = conv.longTime ? LONG_CYCLES : SHORT_CYCLES;
   assign atEnd = running && (count == target - 32'h1);

   // ****************************************************************
   // Counter
   // ****************************************************************
   // Start wins over abort so that an abort-and-restart is one pulse.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 32'h0;
         running <= 1'b0;
         conv.done <= 1'b0;
      end else begin
         conv.done <= atEnd && !conv.start && !conv.abort;
         if (conv.start) begin
            count <= 32'h0;
            running <= 1'b1;
         end else if (conv.abort || atEnd) begin
            running <= 1'b0;
         end else if (running) begin
            count <= count + 32'h1;
         end
      end
   end

   // The done pulse follows exactly the selected number of cycles.
   a_done_length: assert property (@(posedge clk) disable iff (!rst_n)
      conv.done |-> $past(count) == $past(target) - 32'h1)
      else $error("Conversion ended at the wrong count.");
endmodule : lsc_conv_timer
`default_nettype wire

// ---- lsc_ctrl.sv ----
// Conversion control of the light sensor configuration register.
`timescale 1ns/10ps
`default_nettype none
`include "lsc_cfg.svh"
module lsc_ctrl
   import lsc_pkg::*;
#(
   parameter int unsigned SHORT_CYCLES = `LSC_SHORT_CYCLES,
   parameter int unsigned LONG_CYCLES = `LSC_LONG_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Configuration register port
   input wire logic cfgWrite,
   input wire logic [15:0] cfgWrData,
   output logic [15:0] cfgRdData,
   // Flags kept by the comparison logic: ready, high, low
   input wire logic [2:0] flagsIn,
   // Converter front end
   input wire logic adcOverload,
   input wire logic [11:0] adcSample,
   output logic [3:0] rangeApplied,
   output logic convTimeApplied,
   output logic convActive,
   output logic [1:0] resolutionLoss,
   // Result register contents
   output logic [15:0] resultReg
);
   // ****************************************************************
   // Configuration storage
   // ****************************************************************
   lsc_range_t rangeSel;    // Range field as written.
   logic convTimeSel;       // Conversion time bit.
   logic [1:0] modeSel;     // Operating mode field.
   logic overflowFlag;      // Overflow bit of the last measurement.
   logic [4:0] lowCtl;      // Latch, polarity, mask and count bits, stored only.
   lsc_range_t autoRange;   // Range chosen by the automatic mode.
   lsc_state_t state;       // Controller state.
   logic ovfSeen;           // Overload seen during the running conversion.
   lsc_conv_if conv ();     // Link to the timer.

   // ****************************************************************
   // Decoding
   // ****************************************************************
   wire finish = (state == LSC_FINISH);
   wire isAuto = (rangeSel == `LSC_AUTO_CODE);
   wire atMax = (autoRange == `LSC_RANGE_MAX);
   // Overload in auto mode below the top range restarts one range up.
   wire bump = (state == LSC_CONV) && isAuto && adcOverload && !atMax && !cfgWrite;
   // A small result lets the next auto conversion try one range down.
   wire lowResult = (adcSample[11:10] == 2'h0) && (autoRange != 4'h0);
   wire wrActive = (cfgWrData[`LSC_MODE_MSB:`LSC_MODE_LSB] != LSC_SHUTDOWN);
   wire contMode = modeSel[1];
   wire relaunch = finish && contMode && !cfgWrite;
   wire launch = (cfgWrite && wrActive) || relaunch || bump;
   wire stopNow = cfgWrite && !wrActive;
   wire [3:0] effRange = cfgWrite ? cfgWrData[`LSC_RANGE_MSB:`LSC_RANGE_LSB] : rangeSel;
   wire effTime = cfgWrite ? cfgWrData[`LSC_CTIME_BIT] : convTimeSel;
   wire [3:0] next_autoRange = bump ? autoRange + 4'h1 :
      (finish && isAuto && !ovfSeen && lowResult) ? autoRange - 4'h1 : autoRange;
   // Reserved codes are never written; if one is, it acts as the top range.
   wire [3:0] manualRange = (effRange > `LSC_RANGE_MAX) ? `LSC_RANGE_MAX : effRange;
   wire [3:0] launchRange = (effRange == `LSC_AUTO_CODE) ? next_autoRange : manualRange;
   // The short time costs resolution only on the six lowest ranges.
   wire [1:0] next_loss = (effTime || launchRange > `LSC_RANGE_LOSSY) ? 2'h0 :
      (launchRange == `LSC_RANGE_LOSSY) ? 2'h1 :
      (launchRange == 4'h0) ? 2'h3 : 2'h2;
   wire [15:0] cfgWord = {rangeSel, convTimeSel, modeSel, overflowFlag, flagsIn, lowCtl};
   lsc_state_t next_state;

   // ****************************************************************
   // State machine
   // ****************************************************************
   always_comb begin
      if (launch) begin
         next_state = LSC_CONV;
      end else if (stopNow) begin
         next_state = LSC_IDLE;
      end else begin
         case (state)
            LSC_IDLE: next_state = LSC_IDLE;
            // A done pulse that meets a fresh start belongs to the aborted run.
            LSC_CONV: next_state = (conv.done && !conv.start) ? LSC_FINISH : LSC_CONV;
            LSC_FINISH: next_state = LSC_IDLE;
            default: next_state = LSC_IDLE;
         endcase
      end
   end

   // State and activity; activity is registered so the port comes from a flop.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= LSC_IDLE;
         convActive <= 1'b0;
      end else begin
         state <= next_state;
         convActive <= (next_state != LSC_IDLE);
      end
   end

   // ****************************************************************
   // Configuration register
   // ****************************************************************
   // A host write replaces every writable field; ready and limit flags are
   // never touched here, so shutdown leaves them readable as they were.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rangeSel <= `LSC_RANGE_RESET;
         convTimeSel <= `LSC_CTIME_RESET;
         modeSel <= LSC_SHUTDOWN;
         lowCtl <= `LSC_LOWCTL_RESET;
      end else if (cfgWrite) begin
         rangeSel <= cfgWrData[`LSC_RANGE_MSB:`LSC_RANGE_LSB];
         convTimeSel <= cfgWrData[`LSC_CTIME_BIT];
         modeSel <= cfgWrData[`LSC_MODE_MSB:`LSC_MODE_LSB];
         lowCtl <= cfgWrData[4:0];
      end else if (finish && modeSel == LSC_SINGLE) begin
         modeSel <= LSC_SHUTDOWN;
      end
   end

   // Read word is refreshed every cycle; the flag inputs pass untouched.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfgRdData <= `LSC_RESET_WORD;
      end else begin
         cfgRdData <= cfgWord;
      end
   end

   // ****************************************************************
   // Conversion launch and automatic range
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         autoRange <= 4'h0;
         rangeApplied <= 4'h0;
         convTimeApplied <= `LSC_CTIME_RESET;
         resolutionLoss <= 2'h0;
         conv.start <= 1'b0;
         conv.abort <= 1'b0;
      end else begin
         autoRange <= next_autoRange;
         conv.start <= launch;
         conv.abort <= stopNow;
         if (launch) begin
            rangeApplied <= launchRange;
            convTimeApplied <= effTime;
            resolutionLoss <= next_loss;
         end
      end
   end
   assign conv.longTime = convTimeApplied;

   // ****************************************************************
   // Overflow and result
   // ****************************************************************
   // The overflow bit is rebuilt at each finished measurement. In manual
   // range a brief overload sets it even if the final sample is in range.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovfSeen <= 1'b0;
         overflowFlag <= 1'b0;
         resultReg <= 16'h0000;
      end else begin
         if (launch) begin
            ovfSeen <= 1'b0;
         end else if (state == LSC_CONV && adcOverload) begin
            ovfSeen <= 1'b1;
         end
         if (finish) begin
            overflowFlag <= ovfSeen;
            // Exponent is the range used; the LSB weight ignores the time bit.
            resultReg <= {rangeApplied, adcSample};
         end
      end
   end

   // ****************************************************************
   // Timer
   // ****************************************************************
   lsc_conv_timer #(
      .SHORT_CYCLES(SHORT_CYCLES),
      .LONG_CYCLES(LONG_CYCLES)
   ) u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .conv(conv)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_finish_single;
      finish && modeSel == LSC_SINGLE && !cfgWrite;
   endsequence
   sequence s_shut_idle;
      modeSel == LSC_SHUTDOWN && state == LSC_IDLE;
   endsequence
   a_single_clear: assert property (s_finish_single |=> s_shut_idle)
      else $error("Single-shot did not return to shutdown.");
   a_write_start: assert property (cfgWrite && wrActive |=> state == LSC_CONV && conv.start)
      else $error("Write did not start a conversion.");
   a_write_stop: assert property (cfgWrite && !wrActive |=> state == LSC_IDLE && conv.abort)
      else $error("Shutdown write did not abort.");
   a_cont_again: assert property (finish && contMode && !cfgWrite |=> state == LSC_CONV && conv.start)
      else $error("Continuous mode did not restart.");
   a_auto_bump: assert property (bump |=> autoRange == $past(autoRange) + 4'h1 && conv.start)
      else $error("Auto range did not step up.");
   a_exp_report: assert property (finish |=> resultReg[15:12] == $past(rangeApplied))
      else $error("Exponent does not show the range used.");
   a_ovf_eval: assert property (finish |=> overflowFlag == $past(ovfSeen))
      else $error("Overflow bit not re-evaluated.");
   a_loss_value: assert property (launch && !effTime && launchRange == 4'h0 |=> resolutionLoss == 2'h3)
      else $error("Wrong resolution loss for range zero.");
   a_flags_kept: assert property (##1 cfgRdData[7:5] == $past(flagsIn))
      else $error("Flags changed by the controller.");
   a_range_decode: assert property (launch && !cfgWrite && !isAuto |=> rangeApplied == $past(manualRange))
      else $error("Manual range not applied.");
endmodule : lsc_ctrl
`default_nettype wire

// ---- lsc_adc_model.sv ----
// Behavioural converter front end that faces the conversion controller.
`timescale 1ns/10ps
`default_nettype none
module lsc_adc_model
   import lsc_pkg::*;
(
   // Controller view
   input wire logic convActive,
   input wire lsc_range_t rangeApplied,
   // Scene set by the bench
   input wire lsc_range_t needRange,
   input wire logic [11:0] sampleVal,
   // Converter outputs
   output logic adcOverload,
   output logic [11:0] adcSample
);
   // ****************************************************************
   // Light model
   // ****************************************************************
   // The light overloads every range below the one it needs, and only while converting.
   assign adcOverload = convActive && (rangeApplied < needRange);
   // Outside a conversion the sample is inverted, so a late capture shows up as bad data.
   assign adcSample = convActive ? sampleVal : ~sampleVal;
endmodule : lsc_adc_model
`default_nettype wire

// ---- light_sensor_conversion_control_tb_top.sv ----
// Self-checking bench of the light sensor conversion controller.
`timescale 1ns/10ps
`default_nettype none
module light_sensor_conversion_control_tb_top
   import lsc_pkg::*;
;
   // ****************************************************************
   // Signals
   // ****************************************************************
   localparam int unsigned SHORT_N = 20; // Shortened short conversion count.
   localparam int unsigned LONG_N = 160; // Shortened long conversion count.
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cfgWrite = 1'b0;
   logic [15:0] cfgWrData = 16'h0000;
   logic [2:0] flagsIn = 3'h0;
   lsc_range_t needRange = 4'h0;
   logic [11:0] sampleVal = 12'h9C3;
   logic [15:0] cfgRdData;
   logic [15:0] resultReg;
   logic adcOverload;
   logic [11:0] adcSample;
   lsc_range_t rangeApplied;
   logic convTimeApplied;
   logic convActive;
   logic [1:0] resolutionLoss;
   int fails = 0;
   int nCompared = 0;

   // The clock toggles every half period of 2.5 ns.
   always #2.5 clk = ~clk;

   lsc_ctrl #(.SHORT_CYCLES(SHORT_N), .LONG_CYCLES(LONG_N)) lsc_ctrl_i (
      .clk(clk), .rst_n(rst_n), .cfgWrite(cfgWrite), .cfgWrData(cfgWrData),
      .cfgRdData(cfgRdData), .flagsIn(flagsIn), .adcOverload(adcOverload),
      .adcSample(adcSample), .rangeApplied(rangeApplied),
      .convTimeApplied(convTimeApplied), .convActive(convActive),
      .resolutionLoss(resolutionLoss), .resultReg(resultReg));
   lsc_adc_model lsc_adc_model_i (
      .convActive(convActive), .rangeApplied(rangeApplied), .needRange(needRange),
      .sampleVal(sampleVal), .adcOverload(adcOverload), .adcSample(adcSample));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   // Compares one value and counts it; a mismatch is reported at once.
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      nCompared++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   // Builds a configuration word; the reserved range codes are never built.
   function automatic logic [15:0] cfg(input lsc_range_t rng, input logic ct,
                                       input logic [1:0] md);
      return {rng, ct, md, 9'h010};
   endfunction : cfg

   // One write strobe, then two edges so the read word shows the new fields.
   task automatic cfg_write(input logic [15:0] d);
      @(negedge clk);
      cfgWrite = 1'b1;
      cfgWrData = d;
      @(negedge clk);
      cfgWrite = 1'b0;
      repeat (2) @(negedge clk);
   endtask : cfg_write

   // Waits, bounded, for the conversion to end and returns the cycles waited.
   task automatic wait_idle(output int n);
      n = 0;
      while (convActive !== 1'b0 && n < 400) begin
         @(negedge clk);
         n++;
      end
      check("conversion end", {15'h0, n < 400}, 16'h0001);
      repeat (3) @(negedge clk);
   endtask : wait_idle

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Reset values of the register and of the result, time and activity outputs.
   task automatic t_reset();
      check("config reset", cfgRdData, 16'hC810);
      check("result reset", resultReg, 16'h0000);
      check("time reset", {15'h0, convTimeApplied}, 16'h0001);
      check("idle after reset", {15'h0, convActive}, 16'h0000);
      $display("test reset done");
   endtask : t_reset

   // Automatic range climbs over overloads up to the range that fits.
   task automatic t_auto();
      int n;
      needRange = 4'h5;
      cfg_write(cfg(4'hC, 1'b0, 2'h1));
      check("single mode", {14'h0, cfgRdData[10:9]}, 16'h0001);
      wait_idle(n);
      check("auto result", resultReg, {4'h5, 12'h9C3});
      check("auto config", cfgRdData & 16'hF700, 16'hC000);
      $display("test auto range done");
   endtask : t_auto

   // Every range with both times; each write aborts the one before.
   task automatic t_loss();
      int n;
      logic [1:0] loss;
      needRange = 4'h0;
      for (int c = 0; c < 2; c++) begin
         for (int r = 0; r < 12; r++) begin
            loss = (c == 1) ? 2'h0 : (r == 0) ? 2'h3 : (r <= 4) ? 2'h2 : (r == 5) ? 2'h1 : 2'h0;
            cfg_write(cfg(lsc_range_t'(r), c[0], 2'h1));
            check("applied", {rangeApplied, 9'h0, convTimeApplied, resolutionLoss},
                  {lsc_range_t'(r), 9'h0, c[0], loss});
         end
      end
      wait_idle(n);
      check("long time", {15'h0, n >= LONG_N - 4 && n <= LONG_N + 4}, 16'h0001);
      check("long result", resultReg, {4'hB, 12'h9C3});
      $display("test resolution done");
   endtask : t_loss

   // Manual range overload sets the flag, and the next clean result clears it.
   task automatic t_ovf();
      int n;
      needRange = 4'h7;
      cfg_write(cfg(4'h2, 1'b0, 2'h1));
      wait_idle(n);
      check("manual overload", {resultReg[15:12], 11'h0, cfgRdData[8]}, 16'h2001);
      needRange = 4'h0;
      cfg_write(cfg(4'h2, 1'b0, 2'h1));
      wait_idle(n);
      check("short time", {15'h0, n >= SHORT_N - 4 && n <= SHORT_N + 4}, 16'h0001);
      check("overflow cleared", {15'h0, cfgRdData[8]}, 16'h0000);
      $display("test overflow done");
   endtask : t_ovf

   // Auto range steps down one range after each small result.
   task automatic t_down();
      int n;
      needRange = 4'h0;
      sampleVal = 12'h100;
      cfg_write(cfg(4'hC, 1'b0, 2'h1));
      check("auto lossy range", {14'h0, resolutionLoss}, 16'h0001);
      wait_idle(n);
      check("auto first", resultReg, {4'h5, 12'h100});
      cfg_write(cfg(4'hC, 1'b0, 2'h1));
      wait_idle(n);
      check("auto step down", resultReg, {4'h4, 12'h100});
      $display("test auto step down done");
   endtask : t_down

   // Continuous conversions follow the light; shutdown keeps result and flags.
   task automatic t_cont();
      logic [15:0] keep;
      sampleVal = 12'h123;
      cfg_write(cfg(4'h4, 1'b0, 2'h2));
      repeat (60) @(negedge clk);
      check("continuous first", resultReg, {4'h4, 12'h123});
      sampleVal = 12'h456;
      flagsIn = 3'h5;
      repeat (60) @(negedge clk);
      check("continuous next", resultReg, {4'h4, 12'h456});
      check("continuous mode", {14'h0, cfgRdData[10:9]}, 16'h0002);
      cfg_write(cfg(4'h4, 1'b0, 2'h3));
      check("other continuous", {13'h0, cfgRdData[10:9], convActive}, 16'h0007);
      cfg_write(cfg(4'h4, 1'b0, 2'h0));
      check("shutdown stops", {15'h0, convActive}, 16'h0000);
      keep = resultReg;
      repeat (60) @(negedge clk);
      check("result kept", resultReg, keep);
      check("flags kept", {13'h0, cfgRdData[7:5]}, 16'h0005);
      $display("test continuous done");
   endtask : t_cont

   // ****************************************************************
   // Verdict and sequence
   // ****************************************************************
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", nCompared, fails);
      if (fails == 0 && nCompared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   // Main sequence: eight cycles of reset, then the scenarios.
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      t_reset();
      t_auto();
      t_loss();
      t_ovf();
      t_down();
      t_cont();
      stop_test();
   end

   // The scenarios need under 2,000 cycles; ten times that means a hang.
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test();
   end
endmodule : light_sensor_conversion_control_tb_top
`default_nettype wire
